// *** core/jcn_node.sv ***
`include "jcn_regs.svh"
// Message layer of the CAN node: address claim and version answer.
module jcn_node
  import jcn_pkg::*;
#(
  parameter int          CLK_HZ     = 10000000,
  parameter int          CLAIM_WAIT = (`JCN_CLAIM_WAIT_MS * (CLK_HZ / 1000)),
  parameter logic [63:0] NAME       = 64'h0123456789ABCDEF, // Arbitrary identity value.
  parameter logic [7:0]  FW_MAJOR   = 8'h01,
  parameter logic [7:0]  FW_MINOR   = 8'h00,
  parameter logic [7:0]  FW_PATCH   = 8'h00,
  parameter logic [7:0]  FW_STAGE   = 8'h00,
  parameter logic [7:0]  FW_BUILD   = 8'h00
)
(
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_rx_valid,
  input  wire logic        i_rx_ext,
  input  wire logic [28:0] i_rx_id,
  input  wire logic [3:0]  i_rx_len,
  input  wire logic [63:0] i_rx_data,
  input  wire logic        i_tx_ready,
  input  wire logic [1:0]  i_rate_sel,
  input  wire logic        i_rate_load,
  output logic             o_tx_valid,
  output logic             o_tx_ext,
  output logic [28:0]      o_tx_id,
  output logic [3:0]       o_tx_len,
  output logic [63:0]      o_tx_data,
  output logic [7:0]       o_own_addr,
  output logic             o_claimed,
  output logic [1:0]       o_rate
);
  localparam int WAIT_W = $clog2(CLAIM_WAIT + 1);

  // Parameter sanity check at elaboration: the hold-off needs at least one cycle.
  if (CLAIM_WAIT < 1)
  begin : g_bad_claim_wait
    $error("CLAIM_WAIT must be at least one cycle.");
  end

  logic              rst_s1_r;     // First reset synchroniser stage.
  logic              rst_n_r;      // Synchronised reset, active low.
  jcn_state_t        state_r;      // Sequencer state.
  logic [WAIT_W-1:0] wait_r;       // Claim hold-off counter.
  logic [7:0]        addr_r;       // Address currently tried or held.
  logic              claimed_r;    // Claim has succeeded.
  logic              resp_pend_r;  // A version answer is owed.
  logic [7:0]        resp_dst_r;   // Requester of that answer.
  logic [17:0]       rx_pgn;       // Group number of the received frame.
  logic [7:0]        rx_src;       // Sender of the received frame.
  logic              rx_for_us;    // Received frame is addressed to us.
  logic              rx_ok;        // Usable extended frame this cycle.
  logic              rx_claim;     // Competing claim for our address.
  logic              rx_ver_req;   // Request naming the version group.

  // Builds an identifier from its fields with reserved bit forced low.
  function automatic logic [28:0] jcn_make_id(input logic [2:0] prio, input logic [17:0] pgn,
                                              input logic [7:0] dst, input logic [7:0] sa);
    jcn_id_t id;
    id.prio = prio;
    id.rsvd = 1'b0;
    id.page = pgn[16];
    id.pf   = pgn[15:8];
    id.ps   = (pgn[15:8] < `JCN_PF_BCAST_MIN) ? dst : pgn[7:0];
    id.sa   = sa;
    return id;
  endfunction

  jcn_id_parse jcn_id_parse_inst (
    .i_id       (i_rx_id),
    .i_own_addr (addr_r),
    .o_pgn      (rx_pgn),
    .o_src      (rx_src),
    .o_for_us   (rx_for_us)
  );

  // Reset release through two flip-flops.
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // Receive classification; base frames are ignored.
  always_comb
  begin
    rx_ok = i_rx_valid && i_rx_ext;
    // Lower name wins a contest, as priority does in arbitration.
    rx_claim = rx_ok && (rx_pgn == `JCN_PGN_CLAIM) && (rx_src == addr_r) &&
               (i_rx_len == `JCN_CLAIM_LEN) && (i_rx_data <= NAME);
    rx_ver_req = rx_ok && rx_for_us && (rx_pgn == `JCN_PGN_REQUEST) &&
                 (i_rx_len == `JCN_REQ_LEN) &&
                 ({i_rx_data[55:48], i_rx_data[63:56]} == `JCN_PGN_FWVER_LO16) ;
  end

  // Claim sequencer and transmit side.
  always_ff @(posedge i_clock or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      state_r    <= JCN_ST_CLAIM_TX;
      addr_r     <= `JCN_ADDR_DEFAULT;
      claimed_r  <= 1'b0;
      wait_r     <= '0;
      o_tx_valid <= 1'b0;
      o_tx_ext   <= 1'b1;
      o_tx_id    <= '0;
      o_tx_len   <= '0;
      o_tx_data  <= '0;
    end
    else
    begin
      unique case (state_r)
        JCN_ST_CLAIM_TX:
        begin
          o_tx_valid <= 1'b1;
          o_tx_id    <= jcn_make_id(`JCN_PRIO_CLAIM, `JCN_PGN_CLAIM, `JCN_ADDR_GLOBAL, addr_r);
          o_tx_len   <= `JCN_CLAIM_LEN;
          o_tx_data  <= NAME;
          if (o_tx_valid && i_tx_ready)
          begin
            o_tx_valid <= 1'b0;
            wait_r     <= WAIT_W'(CLAIM_WAIT);
            state_r    <= JCN_ST_CLAIM_WAIT;
          end
        end
        JCN_ST_CLAIM_WAIT:
        begin
          if (rx_claim)
          begin
            if (addr_r == 8'hFD)
            begin
              addr_r  <= `JCN_ADDR_NULL;
              state_r <= JCN_ST_FAILED;
            end
            else
            begin
              addr_r  <= addr_r + 8'h01;
              state_r <= JCN_ST_CLAIM_TX;
            end
          end
          else if (wait_r == '0)
          begin
            claimed_r <= 1'b1;
            state_r   <= JCN_ST_IDLE;
          end
          else
          begin
            wait_r <= wait_r - WAIT_W'(1);
          end
        end
        JCN_ST_IDLE:
        begin
          if (rx_claim)
          begin
            // Lost our held address to a stronger claimant.
            claimed_r <= 1'b0;
            state_r   <= JCN_ST_CLAIM_WAIT;
            addr_r    <= (addr_r == 8'hFD) ? `JCN_ADDR_NULL : addr_r + 8'h01;
            wait_r    <= '0;
            if (addr_r != 8'hFD)
            begin
              state_r <= JCN_ST_CLAIM_TX;
            end
            else
            begin
              state_r <= JCN_ST_FAILED;
            end
          end
          else if (resp_pend_r)
          begin
            o_tx_valid <= 1'b1;
            o_tx_id    <= jcn_make_id(`JCN_PRIO_RESP, `JCN_PGN_FWVER, resp_dst_r, addr_r);
            o_tx_len   <= `JCN_FWVER_LEN;
            o_tx_data  <= {FW_MAJOR, FW_MINOR, FW_PATCH, FW_STAGE, FW_BUILD, 24'h000000};
            state_r    <= JCN_ST_RESP_TX;
          end
        end
        JCN_ST_RESP_TX:
        begin
          if (i_tx_ready)
          begin
            o_tx_valid <= 1'b0;
            state_r    <= JCN_ST_IDLE;
          end
        end
        JCN_ST_FAILED:
        begin
          // No address left; only the null address is used.
          o_tx_valid <= 1'b0;
        end
      endcase
    end
  end

  // Pending version answer; a new request wins over completion.
  always_ff @(posedge i_clock or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      resp_pend_r <= 1'b0;
      resp_dst_r  <= `JCN_ADDR_GLOBAL;
    end
    else if (rx_ver_req && claimed_r)
    begin
      resp_pend_r <= 1'b1;
      resp_dst_r  <= rx_src;
    end
    else if (state_r == JCN_ST_RESP_TX && i_tx_ready)
    begin
      resp_pend_r <= 1'b0;
    end
    else if (!claimed_r)
    begin
      // A lost claim drops an owed answer, so no stale reply follows a new claim.
      resp_pend_r <= 1'b0;
    end
  end

  // Bit rate selection held for the controller; loaded from the serial side.
  always_ff @(posedge i_clock or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      o_rate <= `JCN_RATE_DEFAULT;
    end
    else if (i_rate_load && (i_rate_sel <= `JCN_RATE_500))
    begin
      o_rate <= i_rate_sel;
    end
  end

  // Registered copies of address state.
  always_ff @(posedge i_clock or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      o_own_addr <= `JCN_ADDR_DEFAULT;
      o_claimed  <= 1'b0;
    end
    else
    begin
      o_own_addr <= addr_r;
      o_claimed  <= claimed_r;
    end
  end
endmodule

// *** core/jcn_regs.svh ***
// Contract
// - Frames use the extended identifier format.
// - Identifier: priority, reserved, page, format, specific, source.
// - Smaller priority value wins; zero most urgent.
// - Reserved identifier bit transmitted as zero.
// - Format 0..239: specific byte is destination.
// - Format 240..255: broadcast, specific is extension.
// - Group number is reserved, page, format, specific.
// - Low identifier byte holds sender address.
// - Default own address after reset is 128.
// - 255 is global; 254 is null address.
// - Announce address; on conflict claim another.
// - Bit rate 125/250/500, default 250, external select.
// - Request names a group; node sends response. Code answers only the version group, and only once claimed.
// - Version reply: priority 6, group 65242, five bytes.
// - Payload order major, minor, patch, stage, build.
`ifndef JCN_REGS_SVH
`define JCN_REGS_SVH
`define JCN_ADDR_DEFAULT 8'h80
`define JCN_ADDR_GLOBAL 8'hFF
`define JCN_ADDR_NULL 8'hFE
`define JCN_PF_BCAST_MIN 8'hF0
`define JCN_PRIO_RESP 3'h6
`define JCN_PRIO_CLAIM 3'h6
`define JCN_PGN_FWVER 18'h0FEDA
`define JCN_PGN_FWVER_LO16 16'hFEDA
`define JCN_PGN_REQUEST 18'h0EA00
`define JCN_PGN_CLAIM 18'h0EE00
`define JCN_FWVER_LEN 4'h5
`define JCN_CLAIM_LEN 4'h8
`define JCN_REQ_LEN 4'h3
`define JCN_RATE_125 2'h0
`define JCN_RATE_250 2'h1
`define JCN_RATE_500 2'h2
`define JCN_RATE_DEFAULT 2'h1
`define JCN_CLAIM_WAIT_MS 250
`endif

// *** core/jcn_pkg.sv ***
package jcn_pkg;
  // Split fields of a 29-bit extended identifier, most significant first.
  // identifier field order
  typedef struct packed {
    logic [2:0] prio;
    logic       rsvd;
    logic       page;
    logic [7:0] pf;
    logic [7:0] ps;
    logic [7:0] sa;
  } jcn_id_t;
  // Main sequencing states of the node.
  typedef enum logic [2:0] {
    JCN_ST_CLAIM_TX,
    JCN_ST_CLAIM_WAIT,
    JCN_ST_IDLE,
    JCN_ST_RESP_TX,
    JCN_ST_FAILED
  } jcn_state_t;
endpackage

// *** core/jcn_id_parse.sv ***
`include "jcn_regs.svh"
// Splits a received identifier into fields and derived values.
module jcn_id_parse
  import jcn_pkg::*;
(
  input  wire logic [28:0] i_id,
  input  wire logic [7:0]  i_own_addr,
  output logic [17:0]      o_pgn,
  output logic [7:0]       o_src,
  output logic             o_for_us
);
  jcn_id_t f; // Field view of the identifier.
  // Field split and group number derivation.
  always_comb
  begin
    f = jcn_id_t'(i_id);
    o_src = f.sa;
    if (f.pf < `JCN_PF_BCAST_MIN)
    begin
      // Addressed frames drop the destination from the group number.
      o_pgn = {f.rsvd, f.page, f.pf, 8'h00};
      o_for_us = (f.ps == i_own_addr) || (f.ps == `JCN_ADDR_GLOBAL);
    end
    else
    begin
      // Broadcast frames keep the group extension.
      o_pgn = {f.rsvd, f.page, f.pf, f.ps};
      o_for_us = 1'b1;
    end
  end
endmodule

// *** sim/jcn_node_sva.sv ***
// Checker on the node's ports; one clock domain.
module jcn_node_sva (
  input wire logic        i_clock,
  input wire logic        i_rst_n,
  input wire logic        i_rx_valid,
  input wire logic        i_rx_ext,
  input wire logic [28:0] i_rx_id,
  input wire logic [3:0]  i_rx_len,
  input wire logic [63:0] i_rx_data,
  input wire logic        i_tx_ready,
  input wire logic [1:0]  i_rate_sel,
  input wire logic        i_rate_load,
  input wire logic        o_tx_valid,
  input wire logic        o_tx_ext,
  input wire logic [28:0] o_tx_id,
  input wire logic [3:0]  o_tx_len,
  input wire logic [63:0] o_tx_data,
  input wire logic [7:0]  o_own_addr,
  input wire logic        o_claimed,
  input wire logic [1:0]  o_rate
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  chk_tx_ext_form: assert property (o_tx_valid |-> o_tx_ext)
    else $error("tx frame not extended");
  chk_rsvd_bit_zero: assert property (o_tx_valid |-> !o_tx_id[25])
    else $error("reserved bit set");
  chk_tx_frame_stands: assert property (o_tx_valid && !i_tx_ready
    |=> o_tx_valid && $stable(o_tx_id) && $stable(o_tx_data)) else $error("tx frame dropped");
  chk_source_own_addr: assert property (o_tx_valid |-> o_tx_id[7:0] == o_own_addr)
    else $error("source address wrong");
  chk_version_reply: assert property (o_tx_valid && o_tx_id[23:16] == 8'hFE
    |-> o_tx_id[28:26] == 3'h6 && o_tx_id[15:8] == 8'hDA && o_tx_len == 4'h5) else $error("reply form");
  chk_claim_global: assert property (o_tx_valid && o_tx_id[23:16] == 8'hEE
    |-> o_tx_id[15:8] == 8'hFF && o_tx_len == 4'h8) else $error("claim form");
  chk_rate_loads: assert property (i_rate_load && i_rate_sel != 2'h3
    |=> o_rate == $past(i_rate_sel)) else $error("rate not loaded");
  chk_reply_claimed: assert property (o_tx_valid && o_tx_id[23:16] == 8'hFE |-> o_claimed)
    else $error("reply before claim");
  chk_null_unclaimed: assert property (o_own_addr == 8'hFE |-> !o_claimed)
    else $error("null address claimed");
  chk_request_answer: assert property (i_rx_valid && i_rx_ext && o_claimed && !o_tx_valid
    && i_rx_id[23:8] == {8'hEA, o_own_addr} && i_rx_len == 4'h3 && i_rx_data[63:40] == 24'hDAFE00
    |-> ##[1:4] o_tx_valid) else $error("request unanswered");
  cover property (o_tx_valid && i_tx_ready && o_tx_id[23:16] == 8'hFE);
  cover property (o_tx_valid && i_tx_ready && o_tx_id[23:16] == 8'hEE);
  cover property (o_own_addr == 8'h81 && o_claimed);
  cover property (o_own_addr == 8'hFE && !o_claimed);
endmodule
bind jcn_node jcn_node_sva jcn_node_sva_inst (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_rx_valid(i_rx_valid),
  .i_rx_ext(i_rx_ext), .i_rx_id(i_rx_id), .i_rx_len(i_rx_len), .i_rx_data(i_rx_data), .i_tx_ready(i_tx_ready),
  .i_rate_sel(i_rate_sel), .i_rate_load(i_rate_load), .o_tx_valid(o_tx_valid), .o_tx_ext(o_tx_ext),
  .o_tx_id(o_tx_id), .o_tx_len(o_tx_len), .o_tx_data(o_tx_data), .o_own_addr(o_own_addr),
  .o_claimed(o_claimed), .o_rate(o_rate));

// *** sim/jcn_peer.sv ***
// Bus side: a controller that takes frames and a peer that sends them.
module jcn_peer (
  input  wire logic        i_clock,
  input  wire logic        i_tx_valid,
  input  wire logic [28:0] i_tx_id,
  input  wire logic [3:0]  i_tx_len,
  input  wire logic [63:0] i_tx_data,
  output logic             o_tx_ready,
  output logic             o_rx_valid,
  output logic             o_rx_ext,
  output logic [28:0]      o_rx_id,
  output logic [3:0]       o_rx_len,
  output logic [63:0]      o_rx_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // Receive lines rest idle, extended flag up, until the first frame is sent.
  initial
  begin
    o_rx_valid = 1'b0;
    o_rx_ext   = 1'b1;
    o_rx_id    = '0;
    o_rx_len   = '0;
    o_rx_data  = '0;
  end
  int          lag = 0;    // Cycles of stall before ready.
  int          wait_n = 0; // Cycles the frame has waited.
  int          n_tx = 0;   // Frames taken so far.
  logic [28:0] got_id;     // Last frame taken.
  logic [3:0]  got_len;
  logic [63:0] got_data;
  // Ready rises after the stall; the frame is taken at the ready edge.
  always @(posedge i_clock)
  begin
    if (i_tx_valid && o_tx_ready)
    begin
      got_id <= i_tx_id;
      got_len <= i_tx_len;
      got_data <= i_tx_data;
      n_tx <= n_tx + 1;
      o_tx_ready <= 1'b0;
      wait_n <= 0;
    end
    else
    begin
      o_tx_ready <= i_tx_valid && (wait_n >= lag);
      wait_n <= i_tx_valid ? wait_n + 1 : 0;
    end
  end
  // frames sent with the given extended flag
  // One frame for one cycle; id and data lines then show the inverse.
  task send(input logic [28:0] id, input logic ext, input logic [3:0] len, input logic [63:0] data);
    @(posedge i_clock);
    o_rx_valid <= 1'b1;
    o_rx_ext <= ext;
    o_rx_id <= id;
    o_rx_len <= len;
    o_rx_data <= data;
    @(posedge i_clock);
    o_rx_valid <= 1'b0;
    o_rx_id <= ~id;
    o_rx_data <= ~data;
  endtask
endmodule

// *** sim/jcn_node_bench.sv ***
module jcn_node_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0;
  logic rst_n = 0;
  logic [1:0] rate_sel = 2'h1;
  logic rate_load = 0;
  logic tx_valid, tx_ext, tx_ready, rx_valid, rx_ext, claimed;
  logic [28:0] tx_id, rx_id;
  logic [3:0] tx_len, rx_len;
  logic [63:0] tx_data, rx_data;
  logic [7:0] own;
  logic [1:0] rate;
  int n_fail = 0;
  int check_count = 0;
  // Request payload naming the version group.
  localparam logic [63:0] REQ = {24'hDAFE00, 40'h0};
  always #50 clock = ~clock;
  jcn_node #(.CLAIM_WAIT(20), .FW_MAJOR(8'h03), .FW_MINOR(8'h1A), .FW_PATCH(8'h05), .FW_STAGE(8'h02),
    .FW_BUILD(8'h7C)) jcn_node_inst (.i_clock(clock), .i_rst_n(rst_n), .i_rx_valid(rx_valid),
    .i_rx_ext(rx_ext), .i_rx_id(rx_id), .i_rx_len(rx_len), .i_rx_data(rx_data), .i_tx_ready(tx_ready),
    .i_rate_sel(rate_sel), .i_rate_load(rate_load), .o_tx_valid(tx_valid), .o_tx_ext(tx_ext), .o_tx_id(tx_id),
    .o_tx_len(tx_len), .o_tx_data(tx_data), .o_own_addr(own), .o_claimed(claimed), .o_rate(rate));
  jcn_peer jcn_peer_inst (.i_clock(clock), .i_tx_valid(tx_valid), .i_tx_id(tx_id), .i_tx_len(tx_len),
    .i_tx_data(tx_data), .o_tx_ready(tx_ready), .o_rx_valid(rx_valid), .o_rx_ext(rx_ext), .o_rx_id(rx_id),
    .o_rx_len(rx_len), .o_rx_data(rx_data));
  task check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Waits up to n cycles for a frame; reports how many arrived.
  task wait_tx(input int n, input int exp);
    int n0;
    n0 = jcn_peer_inst.n_tx;
    for (int k = 0; k < n && jcn_peer_inst.n_tx == n0; k++)
      @(posedge clock) #1;
    check(64'(jcn_peer_inst.n_tx - n0), 64'(exp));
  endtask
  // Waits for the hold-off to pass without a competing claim.
  task wait_claim;
    for (int k = 0; k < 200 && claimed !== 1'b1; k++)
      @(posedge clock) #1;
    check(claimed, 1'b1);
  endtask
  // Reset is applied and released on rising edges and held for 20 cycles.
  task do_reset;
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
  endtask
  // Sends a version request to dst and judges the reply sent from address sa.
  task ask_version(input logic [7:0] dst, input logic [7:0] sa);
    jcn_peer_inst.send({3'h6, 2'b00, 8'hEA, dst, 8'h21}, 1'b1, 4'h3, REQ);
    wait_tx(30, 1);
    check(jcn_peer_inst.got_id, {3'h6, 2'b00, 8'hFE, 8'hDA, sa});
    check(jcn_peer_inst.got_len, 4'h5);
    check(jcn_peer_inst.got_data[63:24], 40'h031A05027C);
  endtask
  // Loads one rate selection and judges the held rate two cycles later.
  task load_rate(input logic [1:0] sel, input logic [1:0] exp_rate);
    @(posedge clock);
    rate_sel <= sel;
    rate_load <= 1'b1;
    @(posedge clock);
    rate_load <= 1'b0;
    repeat (2) @(posedge clock) #1;
    check(rate, exp_rate);
  endtask
  // Default address and rate, then the first claim; early requests are refused.
  task t_claim;
    check(own, 8'h80);
    check(rate, 2'h1);
    wait_tx(50, 1);
    check(jcn_peer_inst.got_id, {3'h6, 2'b00, 8'hEE, 8'hFF, 8'h80});
    check(jcn_peer_inst.got_len, 4'h8);
    jcn_peer_inst.send({3'h6, 2'b00, 8'hEA, 8'h80, 8'h21}, 1'b1, 4'h3, REQ);
    wait_claim();
    wait_tx(5, 0);
    $display("claim test done");
  endtask
  // Version answers to our address and to the global one; others are ignored.
  task t_version;
    jcn_peer_inst.lag = 3;
    ask_version(8'h80, 8'h80);
    ask_version(8'hFF, 8'h80);
    jcn_peer_inst.send({3'h6, 2'b00, 8'hEA, 8'h33, 8'h21}, 1'b1, 4'h3, REQ);
    wait_tx(10, 0);
    jcn_peer_inst.send({3'h6, 2'b00, 8'hEA, 8'h80, 8'h21}, 1'b0, 4'h3, REQ);
    wait_tx(10, 0);
    $display("version test done");
  endtask
  // The 125 and 500 selections load; the unused code is ignored.
  task t_rate;
    load_rate(2'h0, 2'h0);
    load_rate(2'h2, 2'h2);
    load_rate(2'h3, 2'h2);
    $display("rate test done");
  endtask
  // Mid-run reset, then a competing claim moves the node to the next address.
  task t_conflict;
    do_reset();
    check(rate, 2'h1);
    check(own, 8'h80);
    wait_tx(50, 1);
    jcn_peer_inst.send({3'h6, 2'b00, 8'hEE, 8'hFF, 8'h80}, 1'b1, 4'h8, 64'h0);
    wait_tx(50, 1);
    check(jcn_peer_inst.got_id[7:0], 8'h81);
    wait_claim();
    check(own, 8'h81);
    ask_version(8'h81, 8'h81);
    $display("conflict test done");
  endtask
  // Claims on every address up to the last usable one leave the node on null.
  task t_exhaust;
    logic [7:0] a;
    jcn_peer_inst.lag = 0;
    a = 8'h81;
    while (a != 8'hFD)
    begin
      jcn_peer_inst.send({3'h6, 2'b00, 8'hEE, 8'hFF, a}, 1'b1, 4'h8, 64'h0);
      wait_tx(50, 1);
      a = a + 8'h01;
    end
    check(jcn_peer_inst.got_id[7:0], 8'hFD);
    jcn_peer_inst.send({3'h6, 2'b00, 8'hEE, 8'hFF, 8'hFD}, 1'b1, 4'h8, 64'h0);
    wait_tx(30, 0);
    check(own, 8'hFE);
    check(claimed, 1'b0);
    $display("exhaust test done");
  endtask
  initial
  begin
    do_reset();
    t_claim();
    t_version();
    t_rate();
    t_conflict();
    t_exhaust();
    end_sim();
  end
  // The run needs about 1,000 cycles; the limit allows five times that.
  initial
  begin
    #500000;
    n_fail++;
    end_sim();
  end
endmodule
